// ==== include/dprc_defines.svh ====
// Timing, address and encoding constants for the dual-port RAM host port controller
`ifndef DPRC_DEFINES_SVH
`define DPRC_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define DPRC_CLK_NS 100
// Time the collision decision needs after address and enable settle
`define DPRC_SETTLE_NS 20
`define DPRC_SETTLE_CYC ((`DPRC_SETTLE_NS + `DPRC_CLK_NS - 1) / `DPRC_CLK_NS)
// Least width of a write or read strobe
`define DPRC_STROBE_NS 20
`define DPRC_STROBE_CYC ((`DPRC_STROBE_NS + `DPRC_CLK_NS - 1) / `DPRC_CLK_NS)
// Cycles a blocked write waits for the collision indication to clear
`define DPRC_BUSY_WAIT_MAX 4'hF
`define DPRC_CNT_W 4

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define DPRC_ADDR_W 16
`define DPRC_DATA_W 9
`define DPRC_MBOX_LEFT 16'hFFFE
`define DPRC_MBOX_RIGHT 16'hFFFF
`define DPRC_SEM_IDX_W 3

// ----------------------------------------------------------------------
// Semaphore data levels (active low flags)
// ----------------------------------------------------------------------
`define DPRC_SEM_REQ 9'h000
`define DPRC_SEM_REL 9'h001
`define DPRC_SEM_BIT 0

`endif

// ==== include/dprc_pkg.sv ====
// Types shared by the dual-port RAM host port controller
`include "dprc_defines.svh"

package dprc_pkg;

  // ----------------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_SEM_TAKE,
    OP_SEM_GIVE,
    OP_SEM_READ,
    OP_MBOX_POST,
    OP_MBOX_TAKE
  } dprc_op_t;

  typedef struct packed {
    dprc_op_t op;
    logic [`DPRC_ADDR_W-1:0] addr;
    logic [`DPRC_DATA_W-1:0] data;
  } dprc_cmd_t;

  typedef struct packed {
    logic [`DPRC_DATA_W-1:0] data;
    logic granted;
    logic collided;
  } dprc_rsp_t;

  // ----------------------------------------------------------------------
  // Port pins of one side of the RAM
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic chipEnableN;
    logic readWriteN;
    logic outputEnableN;
    logic flagSpaceSelectN;
    logic [`DPRC_ADDR_W-1:0] addr;
    logic [`DPRC_DATA_W-1:0] dataOut;
    logic dataOeN;
  } dprc_pins_t;

endpackage : dprc_pkg

// ==== hw/dprc_host.sv ====
// Host-side controller driving one port of the shared dual-port RAM
`timescale 1ns/1ps
`include "dprc_defines.svh"

module dprc_host #(
  parameter bit IS_LEFT = 1'b1,
  parameter int DEPTH_PARTS = 1,
  parameter int WIDTH_PARTS = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // User command side
  input wire logic cmdValid,
  output logic cmdReady,
  input dprc_pkg::dprc_cmd_t cmd,
  output logic rspValid,
  output dprc_pkg::dprc_rsp_t rsp,
  output logic mailboxPending,
  input wire logic lockWrites,
  // RAM port pins
  output dprc_pkg::dprc_pins_t pins,
  input wire logic [`DPRC_DATA_W-1:0] dataIn,
  input wire logic [DEPTH_PARTS-1:0] collisionN,
  input wire logic mailboxFlagN,
  output logic slaveInhibitN,
  output logic [WIDTH_PARTS-1:0] masterSelect
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rstnMeta_reg, rstnSync_reg;

  // Two flops so release is glitch free against clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstnMeta_reg <= 1'b0;
      rstnSync_reg <= 1'b0;
    end else begin
      rstnMeta_reg <= 1'b1;
      rstnSync_reg <= rstnMeta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_STROBE, S_GAP, S_DONE} dprc_state_t;

  localparam logic [`DPRC_CNT_W-1:0] SETTLE_LAST = `DPRC_CNT_W'(`DPRC_SETTLE_CYC - 1);
  localparam logic [`DPRC_CNT_W-1:0] STROBE_LAST = `DPRC_CNT_W'(`DPRC_STROBE_CYC - 1);
  localparam logic [`DPRC_ADDR_W-1:0] OWN_MBOX = IS_LEFT ? `DPRC_MBOX_LEFT : `DPRC_MBOX_RIGHT;
  localparam logic [`DPRC_ADDR_W-1:0] PEER_MBOX = IS_LEFT ? `DPRC_MBOX_RIGHT : `DPRC_MBOX_LEFT;

  dprc_state_t state_reg, state_next;
  dprc_pkg::dprc_op_t op_reg, op_next;
  logic [`DPRC_ADDR_W-1:0] addr_reg, addr_next;
  logic [`DPRC_DATA_W-1:0] wdata_reg, wdata_next;
  logic [`DPRC_CNT_W-1:0] cnt_reg, cnt_next, wait_reg, wait_next;
  logic readPhase_reg, readPhase_next, semAcc_reg, semAcc_next;
  dprc_pkg::dprc_rsp_t rsp_reg, rsp_next;
  logic busyAll;

  // Depth-expanded parts each flag a collision; any low one counts
  assign busyAll = &collisionN;

  // Next state of the access sequence
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    cnt_next = cnt_reg;
    wait_next = wait_reg;
    readPhase_next = readPhase_reg;
    semAcc_next = semAcc_reg;
    rsp_next = rsp_reg;
    case (state_reg)
      S_IDLE: begin
        if (cmdValid) begin
          op_next = cmd.op;
          addr_next = cmd.addr;
          wdata_next = cmd.data;
          cnt_next = '0;
          wait_next = '0;
          rsp_next = '0;
          semAcc_next = 1'b0;
          readPhase_next = 1'b0;
          case (cmd.op)
            dprc_pkg::OP_READ: readPhase_next = 1'b1;
            dprc_pkg::OP_SEM_TAKE: begin
              // Request first, then read back: write-then-read avoids the race
              semAcc_next = 1'b1;
              wdata_next = `DPRC_SEM_REQ;
            end
            dprc_pkg::OP_SEM_GIVE: begin
              semAcc_next = 1'b1;
              wdata_next = `DPRC_SEM_REL;
            end
            dprc_pkg::OP_SEM_READ: begin
              semAcc_next = 1'b1;
              readPhase_next = 1'b1;
            end
            dprc_pkg::OP_MBOX_POST: addr_next = PEER_MBOX;
            dprc_pkg::OP_MBOX_TAKE: begin
              // Reading the own mailbox word also clears the flag
              addr_next = OWN_MBOX;
              readPhase_next = 1'b1;
            end
            default: ;
          endcase
          state_next = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (cnt_reg != SETTLE_LAST) begin
          cnt_next = cnt_reg + 1'b1;
        end else if (!semAcc_reg && !busyAll && !readPhase_reg) begin
          // Collision seen: hold the strobe back rather than glitch the inhibit
          if (wait_reg == `DPRC_BUSY_WAIT_MAX) begin
            rsp_next.collided = 1'b1;
            state_next = S_DONE;
          end else begin
            wait_next = wait_reg + 1'b1;
          end
        end else begin
          if (!semAcc_reg && !busyAll) begin
            rsp_next.collided = 1'b1;
          end
          cnt_next = '0;
          state_next = S_STROBE;
        end
      end
      S_STROBE: begin
        if (cnt_reg != STROBE_LAST) begin
          cnt_next = cnt_reg + 1'b1;
        end else begin
          if (readPhase_reg) begin
            rsp_next.data = dataIn;
            rsp_next.granted = semAcc_reg && !dataIn[`DPRC_SEM_BIT];
          end
          state_next = S_GAP;
        end
      end
      S_GAP: begin
        // Pins idle one cycle so the semaphore output latch reopens
        if (op_reg == dprc_pkg::OP_SEM_TAKE && !readPhase_reg) begin
          readPhase_next = 1'b1;
          cnt_next = '0;
          state_next = S_SETTLE;
        end else begin
          state_next = S_DONE;
        end
      end
      S_DONE: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstnSync_reg) begin
    if (!rstnSync_reg) begin
      state_reg <= S_IDLE;
      op_reg <= dprc_pkg::OP_READ;
      addr_reg <= '0;
      wdata_reg <= '0;
      cnt_reg <= '0;
      wait_reg <= '0;
      readPhase_reg <= 1'b0;
      semAcc_reg <= 1'b0;
      rsp_reg <= '0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      cnt_reg <= cnt_next;
      wait_reg <= wait_next;
      readPhase_reg <= readPhase_next;
      semAcc_reg <= semAcc_next;
      rsp_reg <= rsp_next;
    end
  end

  assign cmdReady = (state_reg == S_IDLE);
  assign rspValid = (state_reg == S_DONE);
  assign rsp = rsp_reg;

  // ----------------------------------------------------------------------
  // Pin drive, registered from the next sequencer state
  // ----------------------------------------------------------------------
  dprc_pkg::dprc_pins_t pins_reg, pins_next;
  logic active, strobe;
  logic slaveInhibitN_reg, slaveInhibitN_next, mbox_reg, mbox_next;
  logic [WIDTH_PARTS-1:0] master_reg, master_next;

  // Pins follow state_next so they line up with state_reg
  always_comb begin
    active = (state_next == S_SETTLE) || (state_next == S_STROBE);
    strobe = (state_next == S_STROBE);
    pins_next.chipEnableN = !(active && !semAcc_next);
    pins_next.flagSpaceSelectN = !(active && semAcc_next);
    pins_next.readWriteN = !(strobe && !readPhase_next);
    pins_next.outputEnableN = !(strobe && readPhase_next);
    pins_next.dataOeN = !(active && !readPhase_next);
    pins_next.dataOut = wdata_next;
    pins_next.addr = semAcc_next ? {{(`DPRC_ADDR_W-`DPRC_SEM_IDX_W){1'b0}}, addr_next[`DPRC_SEM_IDX_W-1:0]}
                                 : addr_next;
    slaveInhibitN_next = !lockWrites;
    mbox_next = !mailboxFlagN;
    master_next = {{(WIDTH_PARTS-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk or negedge rstnSync_reg) begin
    if (!rstnSync_reg) begin
      pins_reg <= '{chipEnableN: 1'b1, readWriteN: 1'b1, outputEnableN: 1'b1, flagSpaceSelectN: 1'b1,
                    addr: '0, dataOut: '0, dataOeN: 1'b1};
      slaveInhibitN_reg <= 1'b1;
      mbox_reg <= 1'b0;
      master_reg <= {{(WIDTH_PARTS-1){1'b0}}, 1'b1};
    end else begin
      pins_reg <= pins_next;
      slaveInhibitN_reg <= slaveInhibitN_next;
      mbox_reg <= mbox_next;
      master_reg <= master_next;
    end
  end

  assign pins = pins_reg;
  assign slaveInhibitN = slaveInhibitN_reg;
  assign mailboxPending = mbox_reg;
  assign masterSelect = master_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstnSync_reg);

  logic cmdTaken;
  assign cmdTaken = cmdValid && cmdReady;

  sequence semWriteSeq;
    !pins.readWriteN && !pins.flagSpaceSelectN;
  endsequence
  sequence semReadSeq;
    !pins.outputEnableN && !pins.flagSpaceSelectN;
  endsequence

  chk_flag_space_sel: assert property (!pins.flagSpaceSelectN |-> pins.chipEnableN)
    else $error("flag space selected with chip enable active");
  chk_idle_no_access: assert property (cmdReady |-> pins.chipEnableN && pins.flagSpaceSelectN)
    else $error("port enabled while idle");
  chk_addr_before_wr: assert property ($fell(pins.readWriteN) |-> $past(pins.addr) == pins.addr
                                       && ($past(!pins.chipEnableN) || $past(!pins.flagSpaceSelectN)))
    else $error("write strobe without settled address and enable");
  chk_no_busy_write: assert property ($fell(pins.readWriteN) && !pins.chipEnableN |-> $past(busyAll))
    else $error("write strobe started during collision");
  chk_slave_inhibit: assert property (lockWrites |=> !slaveInhibitN)
    else $error("slave inhibit not following lock request");
  chk_one_master: assert property ($onehot(masterSelect))
    else $error("master select not exactly one part");
  chk_sem_take_seq: assert property (cmdTaken && cmd.op == dprc_pkg::OP_SEM_TAKE
                                     |-> ##[1:8] semWriteSeq ##[2:8] semReadSeq)
    else $error("semaphore take missing write then read");
  chk_sem_oe_gap: assert property (!pins.outputEnableN && !pins.flagSpaceSelectN
                                   |-> ##[1:4] pins.outputEnableN)
    else $error("semaphore read strobe held too long");
  chk_rsp_bound: assert property (cmdTaken |-> ##[3:40] rspValid)
    else $error("no answer to command");

endmodule : dprc_host

// ==== sim/dprc_ram_model.sv ====
// Behavioural model of the host's RAM port: storage, semaphores, mailboxes, collision
`timescale 1ns/1ps
`include "dprc_defines.svh"

module dprc_ram_model (
  // Clock of the host side
  input wire logic clk,
  // Pins of the host port
  input dprc_pkg::dprc_pins_t pins,
  output logic [`DPRC_DATA_W-1:0] dataIn,
  output logic mailboxFlagN,
  output logic busyN,
  // Opposite port activity, set by the bench
  input wire logic peerActive,
  input wire logic [`DPRC_ADDR_W-1:0] peerAddr,
  // Write inhibit driven into the slave part
  input wire logic slaveInhibitN
);
  logic [`DPRC_DATA_W-1:0] mem [0:65535];
  // Slave part of a width-expanded word; it only obeys its inhibit input
  logic [`DPRC_DATA_W-1:0] slaveMem [0:65535];
  logic [`DPRC_DATA_W-1:0] lastOut = 9'h000;
  logic [`DPRC_DATA_W-1:0] semLatch = 9'h000;
  logic semHeld = 1'b0;
  logic rightFlagN = 1'b1;
  logic semSel;
  int holder [8] = '{default: -1};
  bit req [2][8];

  initial mailboxFlagN <= 1'b1;

  // ----------------------------------------------------------------------
  // Semaphores: side 0 is the host, side 1 the peer
  // ----------------------------------------------------------------------
  task automatic semWrite(input int side, input int idx, input bit d0);
    req[side][idx] = !d0;
    if (!d0 && holder[idx] < 0) holder[idx] = side;
    else if (d0 && holder[idx] == side) holder[idx] = req[1-side][idx] ? 1 - side : -1;
  endtask : semWrite

  task automatic peerSem(input int idx, input bit d0);
    semWrite(1, idx, d0);
  endtask : peerSem

  function automatic bit peerSees(input int idx);
    return holder[idx] != 1;
  endfunction : peerSees

  task automatic peerPost(input logic [`DPRC_DATA_W-1:0] d);
    mem[`DPRC_MBOX_LEFT] <= d;
    mailboxFlagN <= 1'b0;
  endtask : peerPost

  task automatic peerTakeRight;
    rightFlagN <= 1'b1;
  endtask : peerTakeRight

  // Master arbitration: the host loses when the peer already holds the location
  assign busyN = !(peerActive && !pins.chipEnableN && pins.addr == peerAddr);
  assign semSel = pins.chipEnableN && !pins.flagSpaceSelectN;

  // A released bus shows the inverse of its last value, so no stale data can pass
  always_comb begin
    dataIn = ~lastOut;
    if (!pins.outputEnableN && !pins.chipEnableN) dataIn = mem[pins.addr];
    if (!pins.outputEnableN && semSel) begin
      dataIn = semHeld ? semLatch : {`DPRC_DATA_W{holder[pins.addr[2:0]] != 0}};
    end
  end

  // Writes land while the strobe is low; a flagged port never writes mem
  always @(posedge clk) begin
    lastOut <= dataIn;
    semHeld <= !pins.outputEnableN && semSel;
    if (!semHeld) semLatch <= dataIn;
    if (!pins.readWriteN && !pins.chipEnableN && busyN) begin
      mem[pins.addr] <= pins.dataOut;
      if (pins.addr == `DPRC_MBOX_RIGHT) rightFlagN <= 1'b0;
    end
    if (!pins.readWriteN && !pins.chipEnableN && slaveInhibitN) slaveMem[pins.addr] <= pins.dataOut;
    if (!pins.readWriteN && semSel) semWrite(0, pins.addr[2:0], pins.dataOut[`DPRC_SEM_BIT]);
    if (!pins.outputEnableN && !pins.chipEnableN && pins.addr == `DPRC_MBOX_LEFT) mailboxFlagN <= 1'b1;
  end
endmodule : dprc_ram_model

// ==== sim/test_dprc_host.sv ====
// Self-checking bench for the host port controller against the RAM port model
`timescale 1ns/1ps
`include "dprc_defines.svh"
`define CHK(w, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", w, e, a); end end

module test_dprc_host;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmdValid = 1'b0;
  logic lockWrites = 1'b0;
  logic extraBusyN = 1'b1;
  logic peerActive = 1'b0;
  logic [`DPRC_ADDR_W-1:0] peerAddr = 16'h0200;
  dprc_pkg::dprc_cmd_t cmd = '0;
  dprc_pkg::dprc_rsp_t rsp;
  dprc_pkg::dprc_pins_t pins;
  logic cmdReady, rspValid, mailboxPending, mailboxFlagN, busyN, slaveInhibitN;
  logic [`DPRC_DATA_W-1:0] dataIn;
  logic [1:0] masterSelect;
  int checked = 0;
  int miscompares = 0;
  int lat;
  int cycles = 0;

  always #50 clk = ~clk;

  dprc_host #(.IS_LEFT(1'b1), .DEPTH_PARTS(2), .WIDTH_PARTS(2)) i_dprc_host (
    .clk(clk), .rstn(rstn), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd), .rspValid(rspValid),
    .rsp(rsp), .mailboxPending(mailboxPending), .lockWrites(lockWrites), .pins(pins), .dataIn(dataIn),
    .collisionN({extraBusyN, busyN}), .mailboxFlagN(mailboxFlagN), .slaveInhibitN(slaveInhibitN),
    .masterSelect(masterSelect));

  dprc_ram_model i_dprc_ram_model (
    .clk(clk), .pins(pins), .dataIn(dataIn), .mailboxFlagN(mailboxFlagN), .busyN(busyN),
    .peerActive(peerActive), .peerAddr(peerAddr), .slaveInhibitN(slaveInhibitN));

  // ----------------------------------------------------------------------
  // Shared command cycle; lat counts cycles from the take edge to rspValid
  // ----------------------------------------------------------------------
  task automatic run(input dprc_pkg::dprc_op_t op, input logic [15:0] a, input logic [8:0] d);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmd <= '{op: op, addr: a, data: d};
    @(posedge clk);
    cmdValid <= 1'b0;
    lat = 1;
    #1;
    while (rspValid !== 1'b1 && lat < 40) begin
      @(posedge clk);
      #1;
      lat++;
    end
  endtask : run

  task automatic t_idle;
    #1;
    `CHK("standbyCe", 1'b1, pins.chipEnableN)
    `CHK("standbySem", 1'b1, pins.flagSpaceSelectN)
    `CHK("oneMaster", 2'h1, masterSelect)
    `CHK("slaveIn", 1'b1, slaveInhibitN)
    `CHK("readyIdle", 1'b1, cmdReady)
    `CHK("noRsp", 1'b0, rspValid)
  endtask : t_idle

  // Mailbox words must behave as plain storage too
  task automatic t_ram;
    logic [15:0] a [3] = '{16'h1234, `DPRC_MBOX_LEFT, `DPRC_MBOX_RIGHT};
    for (int i = 0; i < 3; i++) begin
      run(dprc_pkg::OP_WRITE, a[i], 9'h1A5 ^ 9'(i));
      `CHK("wrLat", 4, lat)
      run(dprc_pkg::OP_READ, a[i], 9'h000);
      `CHK("rdData", 9'h1A5 ^ 9'(i), rsp.data)
      `CHK("rdLat", 4, lat)
    end
  endtask : t_ram

  // Full token procurement walk on every semaphore, upper address bits set
  task automatic t_sem;
    for (int i = 0; i < 8; i++) begin
      run(dprc_pkg::OP_SEM_TAKE, {13'h1FFF, 3'(i)}, 9'h000);
      `CHK("grant", 1'b1, rsp.granted)
      `CHK("takeLat", 7, lat)
      `CHK("peerOne", 1'b1, i_dprc_ram_model.peerSees(i))
      i_dprc_ram_model.peerSem(i, 1'b0);
      run(dprc_pkg::OP_SEM_READ, {13'h1FFF, 3'(i)}, 9'h000);
      `CHK("held", 9'h000, rsp.data)
      run(dprc_pkg::OP_SEM_GIVE, {13'h1FFF, 3'(i)}, 9'h000);
      `CHK("passed", 1'b0, i_dprc_ram_model.peerSees(i))
      run(dprc_pkg::OP_SEM_TAKE, {13'h1FFF, 3'(i)}, 9'h000);
      `CHK("refused", 1'b0, rsp.granted)
      i_dprc_ram_model.peerSem(i, 1'b1);
      run(dprc_pkg::OP_SEM_READ, {13'h1FFF, 3'(i)}, 9'h000);
      `CHK("back", 9'h000, rsp.data)
      run(dprc_pkg::OP_SEM_GIVE, {13'h1FFF, 3'(i)}, 9'h000);
      run(dprc_pkg::OP_SEM_READ, {13'h1FFF, 3'(i)}, 9'h000);
      `CHK("free", 9'h1FF, rsp.data)
      `CHK("peerFree", 1'b1, i_dprc_ram_model.peerSees(i))
    end
  endtask : t_sem

  task automatic t_mbox;
    i_dprc_ram_model.peerTakeRight();
    run(dprc_pkg::OP_MBOX_POST, 16'h0000, 9'h055);
    `CHK("rightFlag", 1'b0, i_dprc_ram_model.rightFlagN)
    `CHK("rightWord", 9'h055, i_dprc_ram_model.mem[`DPRC_MBOX_RIGHT])
    i_dprc_ram_model.peerPost(9'h0AA);
    repeat (3) @(posedge clk);
    #1;
    `CHK("pending", 1'b1, mailboxPending)
    run(dprc_pkg::OP_MBOX_TAKE, 16'h0000, 9'h000);
    `CHK("mboxData", 9'h0AA, rsp.data)
    `CHK("leftClr", 1'b1, mailboxFlagN)
    repeat (2) @(posedge clk);
    #1;
    `CHK("pendClr", 1'b0, mailboxPending)
  endtask : t_mbox

  // Collision: abandoned write, flagged read, late release, depth AND
  task automatic t_busy;
    run(dprc_pkg::OP_WRITE, 16'h0200, 9'h011);
    peerActive <= 1'b1;
    run(dprc_pkg::OP_WRITE, 16'h0200, 9'h122);
    `CHK("wrBusy", 1'b1, rsp.collided)
    `CHK("kept", 9'h011, i_dprc_ram_model.mem[16'h0200])
    `CHK("giveUp", 1'b1, lat > 4 && lat <= 20)
    run(dprc_pkg::OP_READ, 16'h0200, 9'h000);
    `CHK("rdBusy", 1'b1, rsp.collided)
    `CHK("rdBusyData", 9'h011, rsp.data)
    fork
      run(dprc_pkg::OP_WRITE, 16'h0200, 9'h133);
      begin
        repeat (6) @(posedge clk);
        peerActive <= 1'b0;
      end
    join
    `CHK("lateWr", 9'h133, i_dprc_ram_model.mem[16'h0200])
    `CHK("lateOk", 1'b0, rsp.collided)
    @(posedge clk);
    extraBusyN <= 1'b0;
    run(dprc_pkg::OP_WRITE, 16'h0200, 9'h144);
    `CHK("depthAnd", 1'b1, rsp.collided)
    `CHK("kept2", 9'h133, i_dprc_ram_model.mem[16'h0200])
    @(posedge clk);
    extraBusyN <= 1'b1;
  endtask : t_busy

  // Slave write inhibit: normal write lands, locked write leaves the slave word alone
  task automatic t_lock;
    run(dprc_pkg::OP_WRITE, 16'h0300, 9'h0AB);
    `CHK("slaveWr", 9'h0AB, i_dprc_ram_model.slaveMem[16'h0300])
    @(posedge clk);
    lockWrites <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("inhibit", 1'b0, slaveInhibitN)
    run(dprc_pkg::OP_WRITE, 16'h0300, 9'h1CD);
    `CHK("slaveKept", 9'h0AB, i_dprc_ram_model.slaveMem[16'h0300])
    `CHK("masterWr", 9'h1CD, i_dprc_ram_model.mem[16'h0300])
    @(posedge clk);
    lockWrites <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("normal", 1'b1, slaveInhibitN)
  endtask : t_lock

  task results;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_idle();
    t_ram();
    t_sem();
    t_mbox();
    t_busy();
    t_lock();
    results();
  end
endmodule : test_dprc_host
